// >>> logic/fcsf_pkg.sv
// Constants, types and field layout shared by the condition and state-frame unit
package fcsf_pkg;
  // ************************************************************
  // Frame and status word layout
  // ************************************************************
  localparam int WORD_W = 32;
  localparam int EXP_W = 16;
  localparam int MANT_W = 64;
  localparam int FMT_W = 8;
  localparam int VEC_W = 3;
  localparam int PRED_W = 6;
  localparam int FMT_LSB = 8;
  localparam int EXP_LSB = 16;
  localparam logic [FMT_W-1:0] FMT_NULL = 8'h00;
  localparam logic [FMT_W-1:0] FMT_IDLE = 8'h60;
  localparam logic [FMT_W-1:0] FMT_PENDING_EXCEPTION_STATE = 8'he0;
  localparam logic [VEC_W-1:0] VEC_BRANCH_UNORDERED_FLAG = 3'h0;
  localparam logic [VEC_W-1:0] VEC_INEX = 3'h1;
  localparam logic [VEC_W-1:0] VEC_DZ = 3'h2;
  localparam logic [VEC_W-1:0] VEC_UNDERFLOW_EVENT = 3'h3;
  localparam logic [VEC_W-1:0] VEC_INVALID_OPERAND_EVENT = 3'h4;
  localparam logic [VEC_W-1:0] VEC_OVERFLOW_EVENT = 3'h5;
  localparam logic [VEC_W-1:0] VEC_SIGNALING_NAN_EVENT = 3'h6;
  // ************************************************************
  // Status and control register fields
  // ************************************************************
  localparam int FP_CONDITION_CODE_BITS_LSB = 24;
  localparam int EXC_LSB = 8;
  localparam int CC_N = 3;
  localparam int CC_Z = 2;
  localparam int CC_I = 1;
  localparam int CC_NAN = 0;
  localparam int EXC_BRANCH_UNORDERED_FLAG = 7;
  localparam int CTRL_BRANCH_UNORDERED_FLAG_EN = 15;
  localparam logic [WORD_W-1:0] CTRL_RST = 32'h0000_0000;
  localparam logic [WORD_W-1:0] IAR_RST = 32'h0000_0000;
  // ************************************************************
  // Conditional predicate coding
  // ************************************************************
  localparam int PRED_FLAGGING = 4;
  localparam logic [3:0] PRED_EQ = 4'h1;
  localparam logic [3:0] PRED_GT = 4'h2;
  localparam logic [3:0] PRED_LE = 4'h5;
  localparam logic [3:0] PRED_NGT = 4'hd;
  localparam logic [3:0] PRED_NE = 4'he;
  typedef enum logic [1:0] {ST_NULL, ST_IDLE, ST_PENDING_EXCEPTION_STATE} fcsf_state_t;
endpackage

// >>> logic/fcsf_cond_eval.sv
// Conditional test evaluator for the thirty-two floating-point predicates
`timescale 1ns/1ps
module fcsf_cond_eval
  import fcsf_pkg::*;
(
  input wire logic [fcsf_pkg::PRED_W-1:0] pred_i,
  input wire logic [3:0] fp_condition_code_bits_i,
  output logic cond_true_o,
  output logic sets_flag_o
);
  logic n;
  logic z;
  logic u;
  logic [15:0] tab;
  logic [3:0] low;
  // Condition code split
  assign n = fp_condition_code_bits_i[CC_N];
  assign z = fp_condition_code_bits_i[CC_Z];
  assign u = fp_condition_code_bits_i[CC_NAN];
  assign low = pred_i[3:0];
  // Both halves share one equation per low code; bit 4 only picks flagging
  assign tab = {1'b1, ~z, u | z | n, u | (n & ~z), u | z | ~n, u | ~(n | z), u | z, u,
                ~u, ~(u | z), z | (n & ~u), n & ~(u | z), z | ~(u | n), ~(u | z | n), z, 1'b0};
  assign cond_true_o = tab[low];
  // Equal and not-equal never flag even in the flagging half
  assign sets_flag_o = pred_i[PRED_FLAGGING] & u & (low != PRED_EQ) & (low != PRED_NE);
endmodule

// >>> logic/fcsf_frame_pack.sv
// Packs the three-long-word state frame from the unit state
`timescale 1ns/1ps
module fcsf_frame_pack
  import fcsf_pkg::*;
(
  input wire fcsf_pkg::fcsf_state_t state_i,
  input wire logic [fcsf_pkg::VEC_W-1:0] vec_i,
  input wire logic [fcsf_pkg::EXP_W-1:0] exp_i,
  input wire logic [fcsf_pkg::MANT_W-1:0] mant_i,
  output logic [fcsf_pkg::WORD_W-1:0] lw0_o,
  output logic [fcsf_pkg::WORD_W-1:0] lw1_o,
  output logic [fcsf_pkg::WORD_W-1:0] lw2_o
);
  logic is_pending_exception_state;
  logic [FMT_W-1:0] fmt;
  logic [EXP_W-1:0] exp_f;
  logic [VEC_W-1:0] vec_f;
  // Operand fields only carry meaning in exception frames
  assign is_pending_exception_state = (state_i == ST_PENDING_EXCEPTION_STATE);
  assign fmt = is_pending_exception_state ? FMT_PENDING_EXCEPTION_STATE : ((state_i == ST_IDLE) ? FMT_IDLE : FMT_NULL);
  assign exp_f = is_pending_exception_state ? exp_i : '0;
  assign vec_f = is_pending_exception_state ? vec_i : '0;
  // Bits 7:3 of the status word stay zero
  assign lw0_o = {exp_f, fmt, 5'h00, vec_f};
  assign lw1_o = is_pending_exception_state ? mant_i[MANT_W-1:WORD_W] : '0;
  assign lw2_o = is_pending_exception_state ? mant_i[WORD_W-1:0] : '0;
endmodule

// >>> logic/fcsf_top.sv
// Condition evaluation, unordered exception and save/restore state machine
`timescale 1ns/1ps
module fcsf_top
  import fcsf_pkg::*;
(
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic cmp_valid_i,
  input wire logic cmp_a_nan_i,
  input wire logic cmp_b_nan_i,
  input wire logic cmp_less_i,
  input wire logic cmp_equal_i,
  input wire logic branch_valid_i,
  input wire logic [fcsf_pkg::PRED_W-1:0] branch_pred_i,
  input wire logic fp_instr_i,
  input wire logic fp_exc_i,
  input wire logic unsupp_type_i,
  input wire logic [fcsf_pkg::VEC_W-1:0] exc_vector_i,
  input wire logic [7:0] exc_flags_i,
  input wire logic [fcsf_pkg::EXP_W-1:0] exc_exponent_i,
  input wire logic [fcsf_pkg::MANT_W-1:0] exc_mantissa_i,
  input wire logic save_i,
  input wire logic restore_i,
  input wire logic [fcsf_pkg::WORD_W-1:0] restore_lw0_i,
  input wire logic [fcsf_pkg::WORD_W-1:0] restore_lw1_i,
  input wire logic [fcsf_pkg::WORD_W-1:0] restore_lw2_i,
  input wire logic ctrl_we_i,
  input wire logic [fcsf_pkg::WORD_W-1:0] ctrl_wdata_i,
  input wire logic stat_we_i,
  input wire logic [fcsf_pkg::WORD_W-1:0] stat_wdata_i,
  input wire logic iar_we_i,
  input wire logic [fcsf_pkg::WORD_W-1:0] iar_wdata_i,
  output logic branch_done_o,
  output logic branch_taken_o,
  output logic branch_unordered_flag_exc_o,
  output logic frame_valid_o,
  output logic [fcsf_pkg::WORD_W-1:0] frame_lw0_o,
  output logic [fcsf_pkg::WORD_W-1:0] frame_lw1_o,
  output logic [fcsf_pkg::WORD_W-1:0] frame_lw2_o,
  output logic format_error_o,
  output logic [fcsf_pkg::WORD_W-1:0] fp_control_register_o,
  output logic [fcsf_pkg::WORD_W-1:0] fp_status_register_o,
  output logic [fcsf_pkg::WORD_W-1:0] fp_instruction_address_register_o,
  output logic regs_hold_nan_o,
  output logic exc_pending_o,
  output fcsf_pkg::fcsf_state_t state_o
);
  import fcsf_pkg::*;

  // ************************************************************
  // Registers
  // ************************************************************
  fcsf_state_t state_q, state_d;
  logic [VEC_W-1:0] vec_q, vec_d;
  logic [EXP_W-1:0] exp_q, exp_d;
  logic [MANT_W-1:0] mant_q, mant_d;
  logic [3:0] fp_condition_code_bits_q, fp_condition_code_bits_d;
  logic [7:0] exc_q, exc_d;
  logic [WORD_W-1:0] ctrl_q, ctrl_d;
  logic [WORD_W-1:0] iar_q, iar_d;
  logic [WORD_W-1:0] lw0_q, lw1_q, lw2_q;
  logic [WORD_W-1:0] pk0, pk1, pk2;
  logic fv_q, ferr_q, bexc_q, bdone_q, btaken_q;

  // ************************************************************
  // Operation decode
  // ************************************************************
  logic do_rest, do_save, op_free, br, cmp, unord_cmp;
  logic cond_true, flag_set, branch_unordered_flag_take, exc_evt, instr, rst_to_null;
  logic [FMT_W-1:0] fmt_in;
  logic f_null, f_idle, f_pending_exception_state, f_bad;
  logic [3:0] fp_condition_code_bits_cmp, fp_condition_code_bits_wr;
  logic [7:0] exc_wr, exc_set;

  // Restore outranks save; both outrank compare, branch, instruction and exception inputs
  // Register writes lose to a null restore; status writes also lose to a same-cycle compare and to hardware sets
  assign do_rest = restore_i;
  assign do_save = save_i & ~restore_i;
  assign op_free = ~restore_i & ~save_i;
  assign br = branch_valid_i & op_free;
  assign cmp = cmp_valid_i & op_free;
  assign fmt_in = restore_lw0_i[FMT_LSB +: FMT_W];
  assign f_null = (fmt_in == FMT_NULL);
  assign f_idle = (fmt_in == FMT_IDLE);
  assign f_pending_exception_state = (fmt_in == FMT_PENDING_EXCEPTION_STATE);
  assign f_bad = do_rest & ~(f_null | f_idle | f_pending_exception_state);
  assign rst_to_null = do_rest & f_null;

  fcsf_cond_eval u_cond (
    .pred_i(branch_pred_i),
    .fp_condition_code_bits_i(fp_condition_code_bits_q),
    .cond_true_o(cond_true),
    .sets_flag_o(flag_set)
  );

  // Exception taken only when the flag is actually set and enabled
  assign branch_unordered_flag_take = br & flag_set & ctrl_q[CTRL_BRANCH_UNORDERED_FLAG_EN];
  assign exc_evt = (op_free & (fp_exc_i | unsupp_type_i)) | branch_unordered_flag_take;
  // Any compare, branch, instruction or exception op counts as an executed instruction unless save or restore is up; register writes do not
  assign instr = op_free & (fp_instr_i | cmp_valid_i | branch_valid_i | fp_exc_i | unsupp_type_i);

  // Compare result: NaN on either side forces unordered, N and Z clear
  assign unord_cmp = cmp_a_nan_i | cmp_b_nan_i;
  assign fp_condition_code_bits_cmp = {cmp_less_i & ~unord_cmp, cmp_equal_i & ~unord_cmp, 1'b0, unord_cmp};
  assign fp_condition_code_bits_wr = stat_we_i ? stat_wdata_i[FP_CONDITION_CODE_BITS_LSB +: 4] : fp_condition_code_bits_q;
  assign exc_wr = stat_we_i ? stat_wdata_i[EXC_LSB +: 8] : exc_q;
  // Hardware sets; aware tests contribute nothing here
  assign exc_set = (op_free & fp_exc_i ? exc_flags_i : 8'h00)
                 | (br & flag_set ? (8'h01 << EXC_BRANCH_UNORDERED_FLAG) : 8'h00);

  // ************************************************************
  // Status and control next values
  // ************************************************************
  always_comb begin
    fp_condition_code_bits_d = cmp ? fp_condition_code_bits_cmp : fp_condition_code_bits_wr;
    if (br & flag_set) begin
      fp_condition_code_bits_d[CC_NAN] = 1'b1;
    end
    // Set wins over a same-cycle software write
    exc_d = exc_wr | exc_set;
    ctrl_d = ctrl_we_i ? ctrl_wdata_i : ctrl_q;
    iar_d = iar_we_i ? iar_wdata_i : iar_q;
    if (rst_to_null) begin
      fp_condition_code_bits_d = '0;
      exc_d = '0;
      ctrl_d = CTRL_RST;
      iar_d = IAR_RST;
    end
  end

  // ************************************************************
  // State machine
  // ************************************************************
  always_comb begin
    state_d = state_q;
    vec_d = vec_q;
    exp_d = exp_q;
    mant_d = mant_q;
    if (do_rest) begin
      if (f_null) begin
        state_d = ST_NULL;
      end else if (f_idle) begin
        state_d = ST_IDLE;
      end else if (f_pending_exception_state) begin
        state_d = ST_PENDING_EXCEPTION_STATE;
        vec_d = restore_lw0_i[VEC_W-1:0];
        exp_d = restore_lw0_i[EXP_LSB +: EXP_W];
        mant_d = {restore_lw1_i, restore_lw2_i};
      end
    end else if (do_save) begin
      // Save clears the pending exception bit once the frame is taken
      if (state_q == ST_PENDING_EXCEPTION_STATE) begin
        state_d = ST_IDLE;
      end
    end else if (exc_evt) begin
      state_d = ST_PENDING_EXCEPTION_STATE;
      vec_d = branch_unordered_flag_take ? VEC_BRANCH_UNORDERED_FLAG : exc_vector_i;
      exp_d = exc_exponent_i;
      mant_d = exc_mantissa_i;
    end else begin
      unique case (state_q)
        ST_NULL: state_d = instr ? ST_IDLE : ST_NULL;
        ST_IDLE: state_d = ST_IDLE;
        ST_PENDING_EXCEPTION_STATE: state_d = ST_PENDING_EXCEPTION_STATE;
      endcase
    end
  end

  // Frame built from the state as it stands before this save
  fcsf_frame_pack u_pack (
    .state_i(state_q),
    .vec_i(vec_q),
    .exp_i(exp_q),
    .mant_i(mant_q),
    .lw0_o(pk0),
    .lw1_o(pk1),
    .lw2_o(pk2)
  );

  // Reset lands in null with cleared registers
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_q <= ST_NULL;
      vec_q <= '0;
      exp_q <= '0;
      mant_q <= '0;
      fp_condition_code_bits_q <= '0;
      exc_q <= '0;
      ctrl_q <= CTRL_RST;
      iar_q <= IAR_RST;
    end else begin
      state_q <= state_d;
      vec_q <= vec_d;
      exp_q <= exp_d;
      mant_q <= mant_d;
      fp_condition_code_bits_q <= fp_condition_code_bits_d;
      exc_q <= exc_d;
      ctrl_q <= ctrl_d;
      iar_q <= iar_d;
    end
  end

  // Frame and result registers; lw words hold until the next save
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      lw0_q <= '0;
      lw1_q <= '0;
      lw2_q <= '0;
      fv_q <= 1'b0;
      ferr_q <= 1'b0;
      bexc_q <= 1'b0;
      bdone_q <= 1'b0;
      btaken_q <= 1'b0;
    end else begin
      if (do_save) begin
        lw0_q <= pk0;
        lw1_q <= pk1;
        lw2_q <= pk2;
      end
      fv_q <= do_save;
      ferr_q <= f_bad;
      bexc_q <= branch_unordered_flag_take;
      bdone_q <= br;
      btaken_q <= br & cond_true;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign branch_done_o = bdone_q;
  assign branch_taken_o = btaken_q;
  assign branch_unordered_flag_exc_o = bexc_q;
  assign frame_valid_o = fv_q;
  assign frame_lw0_o = lw0_q;
  assign frame_lw1_o = lw1_q;
  assign frame_lw2_o = lw2_q;
  assign format_error_o = ferr_q;
  assign fp_control_register_o = ctrl_q;
  assign fp_status_register_o = ({28'h0, fp_condition_code_bits_q} << FP_CONDITION_CODE_BITS_LSB) | ({24'h0, exc_q} << EXC_LSB);
  assign fp_instruction_address_register_o = iar_q;
  // Datapath reads default NaN for every data register while null
  assign regs_hold_nan_o = (state_q == ST_NULL);
  assign exc_pending_o = (state_q == ST_PENDING_EXCEPTION_STATE);
  assign state_o = state_q;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  AST_UNORD_CMP: assert property (cmp && unord_cmp |=> fp_condition_code_bits_q[CC_NAN] && !fp_condition_code_bits_q[CC_Z])
    else $error("NaN compare not unordered");
  AST_BRANCH_UNORDERED_FLAG_FLAG: assert property (br && branch_pred_i[PRED_FLAGGING] && fp_condition_code_bits_q[CC_NAN]
      && branch_pred_i[3:0] != PRED_EQ && branch_pred_i[3:0] != PRED_NE |=> exc_q[EXC_BRANCH_UNORDERED_FLAG])
    else $error("Flagging test did not set branch-unordered flag");
  AST_BRANCH_UNORDERED_FLAG_EXC: assert property (br && flag_set && ctrl_q[CTRL_BRANCH_UNORDERED_FLAG_EN]
      |=> branch_unordered_flag_exc_o && state_q == ST_PENDING_EXCEPTION_STATE && vec_q == VEC_BRANCH_UNORDERED_FLAG)
    else $error("Enabled branch-unordered exception not taken");
  AST_AWARE_KEEP: assert property (br && !branch_pred_i[PRED_FLAGGING] && !stat_we_i && !fp_exc_i
      |=> exc_q[EXC_BRANCH_UNORDERED_FLAG] == $past(exc_q[EXC_BRANCH_UNORDERED_FLAG]))
    else $error("Aware test changed branch-unordered flag");
  AST_NGT_TRUE: assert property (br && fp_condition_code_bits_q[CC_NAN] && branch_pred_i[3:0] == PRED_NGT
      |=> branch_done_o && branch_taken_o)
    else $error("Not-greater false after unordered");
  AST_GT_LE_FALSE: assert property (br && fp_condition_code_bits_q[CC_NAN]
      && (branch_pred_i[3:0] == PRED_GT || branch_pred_i[3:0] == PRED_LE) |=> !branch_taken_o)
    else $error("Greater or less-equal true after unordered");
  AST_FRAME_FMT: assert property (do_save |=> frame_valid_o && frame_lw0_o[FMT_LSB +: FMT_W]
      == ($past(state_q) == ST_PENDING_EXCEPTION_STATE ? FMT_PENDING_EXCEPTION_STATE : $past(state_q) == ST_IDLE ? FMT_IDLE : FMT_NULL))
    else $error("Frame format does not match saved state");
  AST_STATUS_ZERO: assert property (frame_valid_o |-> frame_lw0_o[7:3] == 5'h00)
    else $error("Status word reserved bits not zero");
  AST_FMT_ERR: assert property (f_bad |=> format_error_o && state_q == $past(state_q))
    else $error("Bad restore format not refused");
  AST_SAVE_CLR: assert property (do_save |=> state_q != ST_PENDING_EXCEPTION_STATE)
    else $error("Save left exception pending");
  AST_NULL_EXIT: assert property (state_q == ST_NULL && instr && !exc_evt |=> state_q == ST_IDLE)
    else $error("Null state not left on instruction");
  AST_REST_PENDING_EXCEPTION_STATE: assert property (do_rest && f_pending_exception_state |=> exc_pending_o)
    else $error("Exception restore did not enter exception state");
  AST_REST_NULL: assert property (rst_to_null |=> regs_hold_nan_o && fp_control_register_o == CTRL_RST)
    else $error("Null restore did not return to null");

  COV_BRANCH_UNORDERED_FLAG_EXC: cover property (branch_unordered_flag_take ##2 do_save);
  COV_REST_PENDING_EXCEPTION_STATE: cover property (do_rest && f_pending_exception_state);
  COV_FMT_ERR: cover property (f_bad);
  COV_NULL_IDLE: cover property (state_q == ST_NULL ##1 state_q == ST_IDLE);
endmodule

// >>> sim/fcsf_pipe_model.sv
// Pipeline model issuing floating-point operations to the unit
`timescale 1ns/1ps
module fcsf_pipe_model
  import fcsf_pkg::*;
(
  input wire logic clk_i,
  output logic cmp_valid_i,
  output logic cmp_a_nan_i,
  output logic cmp_b_nan_i,
  output logic cmp_less_i,
  output logic cmp_equal_i,
  output logic branch_valid_i,
  output logic [fcsf_pkg::PRED_W-1:0] branch_pred_i,
  output logic fp_instr_i,
  output logic fp_exc_i,
  output logic unsupp_type_i,
  output logic [fcsf_pkg::VEC_W-1:0] exc_vector_i,
  output logic [7:0] exc_flags_i,
  output logic [fcsf_pkg::EXP_W-1:0] exc_exponent_i,
  output logic [fcsf_pkg::MANT_W-1:0] exc_mantissa_i,
  output logic save_i,
  output logic restore_i,
  output logic [fcsf_pkg::WORD_W-1:0] restore_lw0_i,
  output logic [fcsf_pkg::WORD_W-1:0] restore_lw1_i,
  output logic [fcsf_pkg::WORD_W-1:0] restore_lw2_i,
  output logic ctrl_we_i,
  output logic [fcsf_pkg::WORD_W-1:0] ctrl_wdata_i,
  output logic stat_we_i,
  output logic [fcsf_pkg::WORD_W-1:0] stat_wdata_i,
  output logic iar_we_i,
  output logic [fcsf_pkg::WORD_W-1:0] iar_wdata_i
);
  // ************************************************************
  // Operation issue, one pulse per op, launched at the falling edge
  // ************************************************************
  // Strobes drop and payloads invert, so stale data never looks valid
  task automatic idle();
    {cmp_valid_i, branch_valid_i, fp_instr_i, fp_exc_i, unsupp_type_i, save_i, restore_i} = '0;
    {ctrl_we_i, stat_we_i, iar_we_i} = '0;
    {cmp_a_nan_i, cmp_b_nan_i, cmp_less_i, cmp_equal_i, branch_pred_i, exc_vector_i, exc_flags_i} =
      ~{cmp_a_nan_i, cmp_b_nan_i, cmp_less_i, cmp_equal_i, branch_pred_i, exc_vector_i, exc_flags_i};
    {exc_exponent_i, exc_mantissa_i, restore_lw0_i, restore_lw1_i, restore_lw2_i} =
      ~{exc_exponent_i, exc_mantissa_i, restore_lw0_i, restore_lw1_i, restore_lw2_i};
    {ctrl_wdata_i, stat_wdata_i, iar_wdata_i} = ~{ctrl_wdata_i, stat_wdata_i, iar_wdata_i};
  endtask

  // Defined payloads from time zero
  initial begin
    {cmp_a_nan_i, cmp_b_nan_i, cmp_less_i, cmp_equal_i, branch_pred_i, exc_vector_i, exc_flags_i} = '0;
    {exc_exponent_i, exc_mantissa_i, restore_lw0_i, restore_lw1_i, restore_lw2_i} = '0;
    {ctrl_wdata_i, stat_wdata_i, iar_wdata_i} = '0;
    {cmp_valid_i, branch_valid_i, fp_instr_i, fp_exc_i, unsupp_type_i, save_i, restore_i} = '0;
    {ctrl_we_i, stat_we_i, iar_we_i} = '0;
  end

  task automatic cmp(input logic a, input logic b, input logic l, input logic e);
    @(negedge clk_i);
    {cmp_valid_i, cmp_a_nan_i, cmp_b_nan_i, cmp_less_i, cmp_equal_i} = {1'b1, a, b, l, e};
    @(negedge clk_i);
    idle();
  endtask

  task automatic br(input logic [PRED_W-1:0] p);
    @(negedge clk_i);
    {branch_valid_i, branch_pred_i} = {1'b1, p};
    @(negedge clk_i);
    idle();
  endtask

  task automatic ins();
    @(negedge clk_i);
    fp_instr_i = 1'b1;
    @(negedge clk_i);
    idle();
  endtask

  // Unsupported type when u is set, plain floating-point exception otherwise
  task automatic exception_byte(input logic u, input logic [VEC_W-1:0] v, input logic [EXP_W-1:0] e,
                     input logic [MANT_W-1:0] m);
    @(negedge clk_i);
    {fp_exc_i, unsupp_type_i, exc_vector_i, exc_flags_i, exc_exponent_i, exc_mantissa_i} = {~u, u, v, 8'h01, e, m};
    @(negedge clk_i);
    idle();
  endtask

  task automatic sav();
    @(negedge clk_i);
    save_i = 1'b1;
    @(negedge clk_i);
    idle();
  endtask

  task automatic rest(input logic [WORD_W-1:0] w);
    @(negedge clk_i);
    {restore_i, restore_lw0_i, restore_lw1_i, restore_lw2_i} = {1'b1, w, 32'h0000_0000, 32'h0000_0000};
    @(negedge clk_i);
    idle();
  endtask

  // Selector 0 control, 1 status, 2 instruction address
  task automatic wr(input logic [1:0] s, input logic [WORD_W-1:0] d);
    @(negedge clk_i);
    {ctrl_we_i, stat_we_i, iar_we_i} = 3'h4 >> s;
    {ctrl_wdata_i, stat_wdata_i, iar_wdata_i} = {3{d}};
    @(negedge clk_i);
    idle();
  endtask
endmodule

// >>> sim/testbench.sv
// Self-checking bench for the condition and state-frame unit
`timescale 1ns/1ps
module testbench;
  import fcsf_pkg::*;
  logic clk_i, arst_n_i, cmp_valid_i, cmp_a_nan_i, cmp_b_nan_i, cmp_less_i, cmp_equal_i, branch_valid_i;
  logic fp_instr_i, fp_exc_i, unsupp_type_i, save_i, restore_i, ctrl_we_i, stat_we_i, iar_we_i;
  logic [PRED_W-1:0] branch_pred_i;
  logic [VEC_W-1:0] exc_vector_i;
  logic [7:0] exc_flags_i;
  logic [EXP_W-1:0] exc_exponent_i;
  logic [MANT_W-1:0] exc_mantissa_i;
  logic [WORD_W-1:0] restore_lw0_i, restore_lw1_i, restore_lw2_i, ctrl_wdata_i, stat_wdata_i, iar_wdata_i;
  logic branch_done_o, branch_taken_o, branch_unordered_flag_exc_o, frame_valid_o, format_error_o, regs_hold_nan_o, exc_pending_o;
  logic [WORD_W-1:0] frame_lw0_o, frame_lw1_o, frame_lw2_o, fp_control_register_o, fp_status_register_o;
  logic [WORD_W-1:0] fp_instruction_address_register_o;
  fcsf_state_t state_o;
  int errors;
  int check_count;
  // Rows: nan, less, equal, predicate, expected taken, expected flag
  logic [10:0] rows [23] = '{
    {3'b100, 6'h10, 2'b01}, {3'b100, 6'h11, 2'b00}, {3'b100, 6'h12, 2'b01}, {3'b100, 6'h15, 2'b01},
    {3'b100, 6'h1d, 2'b11}, {3'b100, 6'h1e, 2'b10}, {3'b100, 6'h1f, 2'b11}, {3'b100, 6'h00, 2'b00},
    {3'b100, 6'h01, 2'b00}, {3'b100, 6'h02, 2'b00}, {3'b100, 6'h05, 2'b00}, {3'b100, 6'h0d, 2'b10},
    {3'b100, 6'h0e, 2'b10}, {3'b100, 6'h0f, 2'b10}, {3'b000, 6'h12, 2'b10}, {3'b000, 6'h15, 2'b00},
    {3'b000, 6'h1d, 2'b00}, {3'b010, 6'h15, 2'b10}, {3'b010, 6'h12, 2'b00}, {3'b010, 6'h1d, 2'b10},
    {3'b001, 6'h11, 2'b10}, {3'b001, 6'h1e, 2'b00}, {3'b001, 6'h15, 2'b10}};
  // Restore formats: code, expected state, expected format error
  logic [10:0] fmts [6] = '{{8'he0, ST_PENDING_EXCEPTION_STATE, 1'b0}, {8'h60, ST_IDLE, 1'b0}, {8'h40, ST_IDLE, 1'b1},
    {8'h00, ST_NULL, 1'b0}, {8'hff, ST_NULL, 1'b1}, {8'h61, ST_NULL, 1'b1}};

  fcsf_top u_dut (.*);
  fcsf_pipe_model u_pipe (.*);

  // ************************************************************
  // Clock, comparison and verdict
  // ************************************************************
  // 50 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    $display("Mismatches %0d, comparisons %0d", errors, check_count);
    if (errors == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ************************************************************
  // Main sequence
  // ************************************************************
  // Every op returns at the falling edge after the one that took it
  initial begin
    errors = 0;
    check_count = 0;
    arst_n_i = 1'b0;
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    chk(32'({state_o, regs_hold_nan_o, exc_pending_o}), 32'({ST_NULL, 2'b10}));
    chk(fp_control_register_o | fp_status_register_o | fp_instruction_address_register_o, 32'h0);
    arst_n_i = 1'b1;
    u_pipe.sav();
    chk(frame_lw0_o, {16'h0000, FMT_NULL, 8'h00});
    chk(frame_lw1_o | frame_lw2_o, 32'h0);
    chk(32'({frame_valid_o, state_o}), 32'({1'b1, ST_NULL}));
    u_pipe.ins();
    chk(32'({regs_hold_nan_o, state_o}), 32'({1'b0, ST_IDLE}));
    u_pipe.sav();
    chk(frame_lw0_o, {16'h0000, FMT_IDLE, 8'h00});
    // Vector codes 0 to 6, odd codes as unsupported type, even codes as plain exceptions
    for (int v = 0; v < 7; v++) begin
      u_pipe.exception_byte(v[0], v[2:0], {13'h1a5c, v[2:0]}, {32'h1234_5678, 32'(v)});
      chk(32'({exc_pending_o, state_o}), 32'({1'b1, ST_PENDING_EXCEPTION_STATE}));
      u_pipe.sav();
      chk(frame_lw0_o, {13'h1a5c, v[2:0], FMT_PENDING_EXCEPTION_STATE, 5'h00, v[2:0]});
      chk(frame_lw1_o, 32'h1234_5678);
      chk(frame_lw2_o, 32'(v));
      chk(32'({exc_pending_o, state_o}), 32'({1'b0, ST_IDLE}));
    end
    u_pipe.wr(2'h0, 32'h0000_8000);
    chk(fp_control_register_o, 32'h0000_8000);
    u_pipe.wr(2'h2, 32'h1234_5678);
    chk(fp_instruction_address_register_o, 32'h1234_5678);
    // Table of conditional tests, exception enabled, flag cleared first
    foreach (rows[i]) begin
      u_pipe.wr(2'h1, 32'h0);
      u_pipe.cmp(rows[i][10] & i[0], rows[i][10] & ~i[0], rows[i][9], rows[i][8]);
      u_pipe.br(rows[i][7:2]);
      chk(32'({branch_done_o, branch_taken_o, branch_unordered_flag_exc_o, fp_status_register_o[15]}),
          32'({1'b1, rows[i][1], rows[i][0], rows[i][0]}));
      chk(32'(fp_status_register_o[24]), 32'(rows[i][10]));
    end
    // A non-flagging test leaves an already set flag alone
    u_pipe.cmp(1'b1, 1'b1, 1'b0, 1'b0);
    u_pipe.br(6'h12);
    u_pipe.sav();
    chk(32'(frame_lw0_o[15:0]), 32'({FMT_PENDING_EXCEPTION_STATE, 5'h00, VEC_BRANCH_UNORDERED_FLAG}));
    u_pipe.cmp(1'b0, 1'b1, 1'b0, 1'b0);
    u_pipe.br(6'h02);
    chk(32'({branch_unordered_flag_exc_o, fp_status_register_o[15]}), 32'h1);
    // Enable off: flag still set, no exception
    u_pipe.wr(2'h0, 32'h0);
    u_pipe.wr(2'h1, 32'h0);
    u_pipe.cmp(1'b1, 1'b0, 1'b1, 1'b0);
    u_pipe.br(6'h1d);
    chk(32'({branch_unordered_flag_exc_o, fp_status_register_o[15], branch_taken_o}), 32'h3);
    // Restores, good and bad format codes
    foreach (fmts[i]) begin
      u_pipe.rest({16'h0000, fmts[i][10:3], 8'h00});
      chk(32'({format_error_o, state_o}), 32'({fmts[i][0], fmts[i][2:1]}));
    end
    chk(32'(regs_hold_nan_o), 32'h1);
    chk(fp_instruction_address_register_o | fp_control_register_o | fp_status_register_o, 32'h0);
    u_pipe.rest({16'h7abc, FMT_PENDING_EXCEPTION_STATE, 8'h03});
    u_pipe.sav();
    chk(frame_lw0_o, {16'h7abc, FMT_PENDING_EXCEPTION_STATE, 8'h03});
    conclude();
  end
endmodule
